/* pkg/dmm_pkg.sv */
// Constants and types shared by the data memory map decoder.
package dmm_pkg;

	// ---------------------------------------------------------------
	// Data space map
	// ---------------------------------------------------------------
	localparam logic [15:0] IO_LAST = 16'h0FFF;
	localparam logic [15:0] EE_BASE = 16'h1000;
	localparam logic [15:0] EE_LAST = 16'h13FF;
	localparam logic [15:0] SRAM_BASE = 16'h2000;
	localparam logic [15:0] SRAM_LAST = 16'h2FFF;
	localparam int SRAM_BYTES = 4096;
	localparam int SRAM_IDX_W = 12;
	localparam int EE_BYTES = 1024;
	localparam int EE_IDX_W = 10;
	localparam int EE_PAGE_BYTES = 32;
	localparam int EE_BYTE_W = 5;
	localparam int EE_PAGE_W = 6;
	localparam int NVM_ADDR_W = 11;

	// ---------------------------------------------------------------
	// Flash pointer layout
	// ---------------------------------------------------------------
	localparam int FLASH_Z_W = 16;
	localparam int FLASH_PAGE_WORDS = 128;
	localparam int FLASH_WORD_IN_PAGE_W = $clog2(FLASH_PAGE_WORDS);
	localparam int FLASH_PAGE_INDEX_W = FLASH_Z_W - FLASH_WORD_IN_PAGE_W - 1;

	// ---------------------------------------------------------------
	// I/O window
	// ---------------------------------------------------------------
	localparam int IO_SHORT_W = 6;
	localparam logic [15:0] IO_BIT_LAST = 16'h001F;
	localparam int GPR_COUNT = 16;
	localparam int GPR_IDX_W = 4;
	localparam logic [15:0] IO_DEVID0 = 16'h0010;
	localparam logic [15:0] IO_DEVID1 = 16'h0011;
	localparam logic [15:0] IO_DEVID2 = 16'h0012;
	localparam logic [15:0] IO_REV = 16'h0013;
	localparam logic [15:0] IO_CCP = 16'h0014;
	localparam logic [15:0] IO_LOCK = 16'h0015;
	localparam logic [15:0] IO_CLKCFG = 16'h0016;
	localparam logic [15:0] IO_EVCFG = 16'h0017;
	localparam logic [15:0] IO_WEXCFG = 16'h0018;

	// ---------------------------------------------------------------
	// Protection
	// ---------------------------------------------------------------
	localparam int LOCK_W = 3;
	localparam int LOCK_CLK_BIT = 0;
	localparam int LOCK_EV_BIT = 1;
	localparam int LOCK_WEX_BIT = 2;
	localparam logic [2:0] LOCK_RST = 3'h0;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [7:0] CCP_KEY = 8'hA5;
	localparam logic [2:0] CCP_WINDOW = 3'h4;

	// ---------------------------------------------------------------
	// Access latencies in CPU clock cycles
	// ---------------------------------------------------------------
	localparam logic [1:0] LAT_IO = 2'h1;
	localparam logic [1:0] LAT_SRAM_WR = 2'h1;
	localparam logic [1:0] LAT_SRAM_RD = 2'h2;
	localparam logic [1:0] LAT_EE_WR = 2'h1;
	localparam logic [1:0] LAT_EE_RD = 2'h3;

	typedef enum logic [1:0] {
		DMM_BIT_NONE,
		DMM_BIT_SET,
		DMM_BIT_CLR,
		DMM_BIT_TEST
	} dmm_bitop_e;

	typedef enum logic [1:0] {
		DMM_RG_IO,
		DMM_RG_EE,
		DMM_RG_SRAM,
		DMM_RG_NONE
	} dmm_region_e;

endpackage

/* test/dmm_chk.sv */
// Concurrent checks on the data memory map decoder ports.
`timescale 1ns/100ps
module dmm_chk (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_req,
	input wire logic i_we,
	input wire logic i_short,
	input wire logic [1:0] i_bit_op,
	input wire logic [15:0] i_addr,
	input wire logic i_ee_map_en,
	input wire logic [dmm_pkg::NVM_ADDR_W-1:0] i_nvm_addr,
	input wire logic [dmm_pkg::FLASH_Z_W-1:0] i_flash_z,
	input wire logic o_busy,
	input wire logic o_ack,
	input wire logic o_err,
	input wire logic [7:0] o_clk_cfg,
	input wire logic [dmm_pkg::LOCK_W-1:0] o_lock,
	input wire logic [dmm_pkg::FLASH_PAGE_INDEX_W-1:0] o_flash_page_index,
	input wire logic [dmm_pkg::FLASH_WORD_IN_PAGE_W-1:0] o_flash_word_in_page,
	input wire logic [dmm_pkg::EE_PAGE_W-1:0] o_eeprom_page_index,
	input wire logic [dmm_pkg::EE_BYTE_W-1:0] o_eeprom_byte_in_page
);
	// ---------------------------------------------------------------
	// Address classes of a request
	// ---------------------------------------------------------------
	logic io_a;
	logic sr_a;
	logic ee_a;
	logic gap_a;
	assign io_a = i_short || i_addr <= 16'h0FFF;
	assign sr_a = !i_short && i_addr >= 16'h2000 && i_addr <= 16'h2FFF;
	assign ee_a = !i_short && i_addr >= 16'h1000 && i_addr <= 16'h13FF;
	assign gap_a = !i_short && (i_addr >= 16'h3000 ||
		(i_addr >= 16'h1400 && i_addr < 16'h2000));

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	sequence s_take;
		i_req && !o_busy;
	endsequence
	sequence s_wait2;
		o_busy && !o_ack ##1 o_ack && !o_err;
	endsequence
	sequence s_wait3;
		!o_ack [*2] ##1 o_ack && !o_err;
	endsequence

	a_io_one_cycle: assert property (s_take ##0 io_a |=> o_ack)
		else $error("I/O access not acknowledged in one cycle");
	a_sram_rd_two: assert property (s_take ##0 sr_a && !i_we &&
		i_bit_op == 2'h0 |=> s_wait2)
		else $error("SRAM read not answered after two cycles");
	a_sram_wr_one: assert property (s_take ##0 sr_a && i_we |=> o_ack)
		else $error("SRAM write not acknowledged in one cycle");
	a_ee_rd_three: assert property (s_take ##0 ee_a && i_ee_map_en &&
		!i_we && i_bit_op == 2'h0 |=> s_wait3)
		else $error("mapped EEPROM read not answered after three cycles");
	a_gap_err: assert property (s_take ##0 gap_a |=> o_ack && o_err)
		else $error("reserved address not refused");
	a_ee_unmapped: assert property (s_take ##0 ee_a && !i_ee_map_en
		|=> o_ack && o_err)
		else $error("unmapped EEPROM window not refused");
	a_bit_range: assert property (s_take ##0 !i_short &&
		i_bit_op != 2'h0 && i_addr > 16'h001F |=> o_ack && o_err)
		else $error("bit operation above 0x1F not refused");
	a_cfg_locked: assert property (s_take ##0 i_we && !i_short &&
		i_addr == 16'h0016 && o_lock[0] |=> $stable(o_clk_cfg))
		else $error("locked clock configuration changed");
	a_flash_split: assert property (1'b1 |=>
		o_flash_word_in_page == $past(i_flash_z[7:1]) &&
		o_flash_page_index == $past(i_flash_z[15:8]))
		else $error("flash pointer split wrong");
	a_ee_split: assert property (1'b1 |=>
		o_eeprom_byte_in_page == $past(i_nvm_addr[4:0]) &&
		o_eeprom_page_index == $past(i_nvm_addr[10:5]))
		else $error("EEPROM address split wrong");
endmodule

bind dmm_decoder dmm_chk dmm_chk_inst (.i_clk, .i_rst, .i_req, .i_we,
	.i_short, .i_bit_op, .i_addr, .i_ee_map_en, .i_nvm_addr, .i_flash_z,
	.o_busy, .o_ack, .o_err, .o_clk_cfg, .o_lock, .o_flash_page_index,
	.o_flash_word_in_page, .o_eeprom_page_index, .o_eeprom_byte_in_page);

/* test/dmm_cpu.sv */
// CPU core model issuing loads and stores to the decoder.
`timescale 1ns/100ps
module dmm_cpu (
	input wire logic i_clk,
	input wire logic i_busy,
	input wire logic i_ack,
	input wire logic i_err,
	input wire logic [7:0] i_rdata,
	input wire logic i_bit_val,
	output logic o_req,
	output logic o_we,
	output logic o_short,
	output logic [1:0] o_bit_op,
	output logic [2:0] o_bit_sel,
	output logic [15:0] o_addr,
	output logic [7:0] o_wdata
);
	initial begin
		o_req = 1'b0;
		o_we = 1'b0;
		o_short = 1'b0;
		o_bit_op = 2'h0;
		o_bit_sel = 3'h0;
		o_addr = 16'h0000;
		o_wdata = 8'h00;
	end

	// Called at a falling edge; the request stays up so that a following
	// call is taken back to back, and idle withdraws it.
	task automatic access(input logic w, input logic [15:0] a,
		input logic [7:0] d, input logic [1:0] op, input logic [2:0] s,
		input logic sh, output logic [7:0] rd, output logic er,
		output logic bv, output int lat);
		while (i_busy === 1'b1) @(negedge i_clk);
		o_req = 1'b1;
		o_we = w;
		o_short = sh;
		o_bit_op = op;
		o_bit_sel = s;
		o_addr = a;
		o_wdata = d;
		@(negedge i_clk);
		lat = 1;
		while (i_ack !== 1'b1 && lat < 9) begin
			@(negedge i_clk);
			lat++;
		end
		rd = i_rdata;
		er = i_err;
		bv = i_bit_val;
	endtask

	// Released lines show the inverse so no stale value passes as valid.
	task automatic idle;
		o_req = 1'b0;
		o_addr = ~o_addr;
		o_wdata = ~o_wdata;
		@(negedge i_clk);
	endtask
endmodule

/* test/tb.sv */
// Self-checking testbench for the data memory map decoder.
`timescale 1ns/100ps
module tb;
	localparam logic [23:0] ID = 24'hA1_B2C3; // Arbitrary value.
	localparam logic [7:0] REV = 8'h07; // Arbitrary value.
	logic clk, rst, req, we, sh, busy, ack, err, bvo;
	logic map_en, ee_rd, pc, bc, fbyte;
	logic [1:0] op;
	logic [2:0] sel, lock;
	logic [15:0] addr, z;
	logic [7:0] wdata, rdata, ee_rdata, ccfg, ecfg, wcfg;
	logic [10:0] nvm;
	logic [7:0] flash_page_index;
	logic [6:0] flash_word_in_page;
	logic [5:0] epage;
	logic [4:0] ebyte;
	logic [7:0] rd;
	logic er, bv;
	int lat;
	int num_errors = 0;
	int tests_run = 0;

	dmm_decoder #(.DEV_ID(ID), .DEV_REV(REV)) dmm_decoder_inst (
		.i_clk(clk), .i_rst(rst), .i_req(req), .i_we(we), .i_short(sh),
		.i_bit_op(op), .i_bit_sel(sel), .i_addr(addr), .i_wdata(wdata),
		.i_ee_map_en(map_en), .i_ee_rd(ee_rd), .i_ee_page_commit(pc),
		.i_ee_byte_commit(bc), .i_nvm_addr(nvm), .i_flash_z(z),
		.o_busy(busy), .o_ack(ack), .o_err(err), .o_rdata(rdata),
		.o_bit_val(bvo), .o_ee_rdata(ee_rdata), .o_clk_cfg(ccfg),
		.o_ev_cfg(ecfg), .o_wex_cfg(wcfg), .o_lock(lock),
		.o_flash_page_index(flash_page_index), .o_flash_word_in_page(flash_word_in_page),
		.o_flash_byte_sel(fbyte), .o_eeprom_page_index(epage),
		.o_eeprom_byte_in_page(ebyte));
	dmm_cpu dmm_cpu_inst (.i_clk(clk), .i_busy(busy), .i_ack(ack),
		.i_err(err), .i_rdata(rdata), .i_bit_val(bvo), .o_req(req),
		.o_we(we), .o_short(sh), .o_bit_op(op), .o_bit_sel(sel),
		.o_addr(addr), .o_wdata(wdata));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ---------------------------------------------------------------
	// Access and compare tasks
	// ---------------------------------------------------------------
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic go(input logic w, input logic [15:0] a,
		input logic [7:0] d, input logic [1:0] o = 2'h0,
		input logic [2:0] s = 3'h0, input logic h = 1'b0);
		dmm_cpu_inst.access(w, a, d, o, s, h, rd, er, bv, lat);
	endtask
	task automatic rdc(input logic [15:0] a, input logic [7:0] e,
		input logic [7:0] l);
		go(1'b0, a, 8'h00);
		chk(rd, e);
		chk(lat[7:0], l);
		chk({7'h00, er}, 8'h00);
	endtask
	task automatic wrc(input logic [15:0] a, input logic [7:0] d);
		go(1'b1, a, d);
		chk(lat[7:0], 8'h01);
		chk({7'h00, er}, 8'h00);
	endtask
	task automatic erc(input logic [15:0] a, input logic w);
		go(w, a, 8'h5A);
		chk({7'h00, er}, 8'h01);
		chk(rd, 8'h00);
	endtask
	task automatic end_sim;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		#20000;
		num_errors++;
		end_sim();
	end

	initial begin
		{rst, map_en, ee_rd, pc, bc, nvm, z} = {1'b1, 31'h0000_0000};
		repeat (3) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		for (int i = 0; i < 16; i++) wrc(i[15:0], 8'hC0 + i[7:0]);
		for (int i = 0; i < 16; i++) rdc(i[15:0], 8'hC0 + i[7:0], 1);
		go(1'b1, 16'h0004, 8'h00, 2'h2, 3'h2);
		go(1'b0, 16'h0004, 8'h00, 2'h3, 3'h7);
		chk({7'h00, bv}, 8'h01);
		go(1'b0, 16'h0004, 8'h00, 2'h3, 3'h2);
		chk({7'h00, bv}, 8'h00);
		go(1'b1, 16'hFFC4, 8'h00, 2'h1, 3'h0, 1'b1);
		go(1'b0, 16'hFFC4, 8'h00, 2'h0, 3'h0, 1'b1);
		chk(rd, 8'hC1);
		go(1'b1, 16'h0020, 8'h5A, 2'h1);
		chk({7'h00, er}, 8'h01);
		chk(rd, 8'h00);
		rdc(16'h0004, 8'hC1, 1);
		wrc(16'h2000, 8'h3C);
		wrc(16'h2FFF, 8'hE1);
		rdc(16'h2000, 8'h3C, 2);
		rdc(16'h2FFF, 8'hE1, 2);
		erc(16'h3000, 1'b0);
		erc(16'h1FFF, 1'b1);
		erc(16'h1003, 1'b0);
		dmm_cpu_inst.idle();
		map_en = 1'b1;
		wrc(16'h1003, 8'h77);
		wrc(16'h1005, 8'h99);
		erc(16'h1400, 1'b0);
		dmm_cpu_inst.idle();
		pc = 1'b1;
		@(negedge clk);
		pc = 1'b0;
		rdc(16'h1003, 8'h77, 3);
		rdc(16'h1001, 8'h00, 3);
		wrc(16'h1025, 8'h66);
		dmm_cpu_inst.idle();
		nvm = 11'h025;
		bc = 1'b1;
		@(negedge clk);
		{bc, nvm, ee_rd} = {1'b0, 11'h003, 1'b1};
		@(negedge clk);
		ee_rd = 1'b0;
		@(negedge clk);
		chk(ee_rdata, 8'h77);
		rdc(16'h1025, 8'h66, 3);
		rdc(16'h1005, 8'h99, 3);
		for (int i = 0; i < 3; i++) rdc(16'h0010 + i, ID[8*i +: 8], 1);
		wrc(16'h0010, 8'hFF);
		rdc(16'h0010, ID[7:0], 1);
		rdc(16'h0013, REV, 1);
		wrc(16'h0015, 8'h07);
		wrc(16'h0016, 8'h3C);
		wrc(16'h0017, 8'h3D);
		wrc(16'h0018, 8'h3E);
		chk({5'h00, lock}, 8'h00);
		wrc(16'h0014, dmm_pkg::CCP_KEY);
		wrc(16'h0015, 8'h07);
		for (int i = 0; i < 3; i++) wrc(16'h0016 + i, 8'hC3);
		dmm_cpu_inst.idle();
		chk({5'h00, lock}, 8'h07);
		chk(ccfg, 8'h3C);
		chk(ecfg, 8'h3D);
		chk(wcfg, 8'h3E);
		rdc(16'h0016, 8'h3C, 1);
		rdc(16'h0015, 8'h07, 1);
		// A lock write one cycle past the unlock window is ignored.
		wrc(16'h0014, dmm_pkg::CCP_KEY);
		repeat (4) dmm_cpu_inst.idle();
		wrc(16'h0015, 8'h00);
		chk({5'h00, lock}, 8'h07);
		{z, nvm} = {16'hABCD, 11'h5A7};
		repeat (2) @(negedge clk);
		chk(flash_page_index, 8'hAB);
		chk({1'b0, flash_word_in_page}, 8'h66);
		chk({7'h00, fbyte}, 8'h01);
		chk({2'h0, epage}, 8'h2D);
		chk({3'h0, ebyte}, 8'h07);
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		chk({5'h00, lock}, 8'h00);
		chk(ccfg, 8'h00);
		rdc(16'h0000, 8'h00, 1);
		rdc(16'h2000, 8'h3C, 2);
		end_sim();
	end
endmodule

/* verilog/dmm_decoder.sv */
// Data space decoder with access timing, I/O protection and NVM paging.
// Operation
// - One linear byte space, fixed region starts.
// - EEPROM separate by default, mapped at 0x1000.
// - Mapped EEPROM: loads read, stores fill buffer.
// - Loads reach all I/O; short form 0x00-0x3F.
// - Bit set, clear, test for I/O 0x00-0x1F.
// - Lowest 16 I/O addresses are plain storage.
// - I/O read or write takes one cycle.
// - SRAM write one cycle, read two cycles.
// - EEPROM buffer load one, read three cycles.
// - Burst SRAM reads give data every second cycle.
// - Read-only three-byte ID and revision register.
// - Locked protected registers ignore software writes.
// - Lock writes need prior unlock sequence.
// - Flash paged by words, EEPROM by bytes.
// - Flash written per page, read per byte.
// - Flash pointer split into word and page.
// - EEPROM written per page or per byte.
// - EEPROM pages 32 bytes, address split accordingly.
`timescale 1ns/100ps
module dmm_decoder #(
	parameter logic [23:0] DEV_ID = 24'h12_3456, // Arbitrary value.
	parameter logic [7:0] DEV_REV = 8'h01 // Arbitrary value.
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_req,
	input wire logic i_we,
	input wire logic i_short,
	input wire logic [1:0] i_bit_op,
	input wire logic [2:0] i_bit_sel,
	input wire logic [15:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_ee_map_en,
	input wire logic i_ee_rd,
	input wire logic i_ee_page_commit,
	input wire logic i_ee_byte_commit,
	input wire logic [dmm_pkg::NVM_ADDR_W-1:0] i_nvm_addr,
	input wire logic [dmm_pkg::FLASH_Z_W-1:0] i_flash_z,
	output logic o_busy,
	output logic o_ack,
	output logic o_err,
	output logic [7:0] o_rdata,
	output logic o_bit_val,
	output logic [7:0] o_ee_rdata,
	output logic [7:0] o_clk_cfg,
	output logic [7:0] o_ev_cfg,
	output logic [7:0] o_wex_cfg,
	output logic [dmm_pkg::LOCK_W-1:0] o_lock,
	output logic [dmm_pkg::FLASH_PAGE_INDEX_W-1:0] o_flash_page_index,
	output logic [dmm_pkg::FLASH_WORD_IN_PAGE_W-1:0] o_flash_word_in_page,
	output logic o_flash_byte_sel,
	output logic [dmm_pkg::EE_PAGE_W-1:0] o_eeprom_page_index,
	output logic [dmm_pkg::EE_BYTE_W-1:0] o_eeprom_byte_in_page
);
	typedef enum logic {DMM_IDLE, DMM_WAIT} dmm_state_e;

	dmm_state_e st_q;
	logic [1:0] wait_q;
	logic rd_ee_q;
	logic [dmm_pkg::SRAM_IDX_W-1:0] rd_idx_q;
	logic [2:0] ccp_cnt_q;
	logic [7:0] sram_q [dmm_pkg::SRAM_BYTES];
	logic [7:0] ee_q [dmm_pkg::EE_BYTES];
	logic [7:0] pbuf_q [dmm_pkg::EE_PAGE_BYTES];

	logic take;
	logic [15:0] ea;
	dmm_pkg::dmm_region_e region;
	dmm_pkg::dmm_bitop_e bop;
	logic bit_ok;
	logic bad;
	logic [1:0] lat;
	logic [7:0] io_rd;
	logic [7:0] mask;
	logic [7:0] io_wval;
	logic io_we;
	logic [7:0] gpr_rd;
	logic gpr_we;
	logic [dmm_pkg::EE_IDX_W-dmm_pkg::EE_BYTE_W-1:0] cpage;

	// ---------------------------------------------------------------
	// Address decode
	// ---------------------------------------------------------------
	assign take = i_req && st_q == DMM_IDLE;
	assign bop = dmm_pkg::dmm_bitop_e'(i_bit_op);

	always_comb begin
		// Short form reaches only the low 64 I/O addresses.
		ea = i_short ? {10'h000, i_addr[dmm_pkg::IO_SHORT_W-1:0]} : i_addr;
		if (ea <= dmm_pkg::IO_LAST) begin
			region = dmm_pkg::DMM_RG_IO;
		end else if (ea >= dmm_pkg::EE_BASE && ea <= dmm_pkg::EE_LAST &&
			i_ee_map_en) begin
			region = dmm_pkg::DMM_RG_EE;
		end else if (ea >= dmm_pkg::SRAM_BASE && ea <= dmm_pkg::SRAM_LAST) begin
			region = dmm_pkg::DMM_RG_SRAM;
		end else begin
			region = dmm_pkg::DMM_RG_NONE;
		end
	end

	// Bit operations exist only in the low 32 I/O addresses.
	assign bit_ok = bop == dmm_pkg::DMM_BIT_NONE ||
		(region == dmm_pkg::DMM_RG_IO && ea <= dmm_pkg::IO_BIT_LAST);
	assign bad = region == dmm_pkg::DMM_RG_NONE || !bit_ok;

	always_comb begin
		case (region)
			dmm_pkg::DMM_RG_SRAM:
				lat = i_we ? dmm_pkg::LAT_SRAM_WR : dmm_pkg::LAT_SRAM_RD;
			dmm_pkg::DMM_RG_EE:
				lat = i_we ? dmm_pkg::LAT_EE_WR : dmm_pkg::LAT_EE_RD;
			default:
				lat = dmm_pkg::LAT_IO;
		endcase
	end

	// ---------------------------------------------------------------
	// I/O registers
	// ---------------------------------------------------------------
	dmm_gpr_file u_gpr (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_we(gpr_we),
		.i_idx(ea[dmm_pkg::GPR_IDX_W-1:0]),
		.i_wdata(io_wval),
		.o_rdata(gpr_rd)
	);

	always_comb begin
		case (ea)
			dmm_pkg::IO_DEVID0: io_rd = DEV_ID[7:0];
			dmm_pkg::IO_DEVID1: io_rd = DEV_ID[15:8];
			dmm_pkg::IO_DEVID2: io_rd = DEV_ID[23:16];
			dmm_pkg::IO_REV: io_rd = DEV_REV;
			dmm_pkg::IO_LOCK: io_rd = {5'h00, o_lock};
			dmm_pkg::IO_CLKCFG: io_rd = o_clk_cfg;
			dmm_pkg::IO_EVCFG: io_rd = o_ev_cfg;
			dmm_pkg::IO_WEXCFG: io_rd = o_wex_cfg;
			default: begin
				if (ea < 16'(dmm_pkg::GPR_COUNT)) begin
					io_rd = gpr_rd;
				end else begin
					io_rd = 8'h00;
				end
			end
		endcase
	end

	// Bit set and clear are a single-cycle read-modify-write.
	assign mask = 8'h01 << i_bit_sel;

	always_comb begin
		case (bop)
			dmm_pkg::DMM_BIT_SET: io_wval = io_rd | mask;
			dmm_pkg::DMM_BIT_CLR: io_wval = io_rd & ~mask;
			default: io_wval = i_wdata;
		endcase
	end

	assign io_we = take && !bad && region == dmm_pkg::DMM_RG_IO &&
		bop != dmm_pkg::DMM_BIT_TEST &&
		(i_we || bop != dmm_pkg::DMM_BIT_NONE);
	assign gpr_we = io_we && ea < 16'(dmm_pkg::GPR_COUNT);

	// ---------------------------------------------------------------
	// Configuration change protection and locks
	// ---------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ccp_cnt_q <= 3'h0;
		end else if (io_we && ea == dmm_pkg::IO_CCP &&
			io_wval == dmm_pkg::CCP_KEY) begin
			ccp_cnt_q <= dmm_pkg::CCP_WINDOW;
		end else if (ccp_cnt_q != 3'h0) begin
			ccp_cnt_q <= ccp_cnt_q - 3'h1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_lock <= dmm_pkg::LOCK_RST;
		end else if (io_we && ea == dmm_pkg::IO_LOCK && ccp_cnt_q != 3'h0) begin
			o_lock <= io_wval[dmm_pkg::LOCK_W-1:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_clk_cfg <= dmm_pkg::CFG_RST;
			o_ev_cfg <= dmm_pkg::CFG_RST;
			o_wex_cfg <= dmm_pkg::CFG_RST;
		end else if (io_we) begin
			if (ea == dmm_pkg::IO_CLKCFG && !o_lock[dmm_pkg::LOCK_CLK_BIT]) begin
				o_clk_cfg <= io_wval;
			end
			if (ea == dmm_pkg::IO_EVCFG && !o_lock[dmm_pkg::LOCK_EV_BIT]) begin
				o_ev_cfg <= io_wval;
			end
			if (ea == dmm_pkg::IO_WEXCFG && !o_lock[dmm_pkg::LOCK_WEX_BIT]) begin
				o_wex_cfg <= io_wval;
			end
		end
	end

	// ---------------------------------------------------------------
	// Internal SRAM and EEPROM storage
	// ---------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (take && !bad && i_we && region == dmm_pkg::DMM_RG_SRAM) begin
			sram_q[ea[dmm_pkg::SRAM_IDX_W-1:0]] <= i_wdata;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			for (int b = 0; b < dmm_pkg::EE_PAGE_BYTES; b++) begin
				pbuf_q[b] <= dmm_pkg::CFG_RST;
			end
		end else if (take && !bad && i_we && region == dmm_pkg::DMM_RG_EE) begin
			pbuf_q[ea[dmm_pkg::EE_BYTE_W-1:0]] <= i_wdata;
		end
	end

	assign cpage = i_nvm_addr[dmm_pkg::EE_IDX_W-1:dmm_pkg::EE_BYTE_W];

	// A page commit wins over a byte commit in the same cycle.
	always_ff @(posedge i_clk) begin
		if (i_ee_page_commit) begin
			for (int b = 0; b < dmm_pkg::EE_PAGE_BYTES; b++) begin
				ee_q[{cpage, dmm_pkg::EE_BYTE_W'(b)}] <= pbuf_q[b];
			end
		end else if (i_ee_byte_commit) begin
			ee_q[i_nvm_addr[dmm_pkg::EE_IDX_W-1:0]] <=
				pbuf_q[i_nvm_addr[dmm_pkg::EE_BYTE_W-1:0]];
		end
	end

	// Separate-space EEPROM read, one byte at a time.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_ee_rdata <= 8'h00;
		end else if (i_ee_rd) begin
			o_ee_rdata <= ee_q[i_nvm_addr[dmm_pkg::EE_IDX_W-1:0]];
		end
	end

	// ---------------------------------------------------------------
	// Access sequencing
	// ---------------------------------------------------------------
	// The next access is taken in the cycle that acknowledges a read,
	// so back-to-back SRAM reads deliver data every second cycle.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_q <= DMM_IDLE;
			wait_q <= 2'h0;
			rd_ee_q <= 1'b0;
			rd_idx_q <= '0;
		end else begin
			case (st_q)
				DMM_IDLE: begin
					if (take && !bad && lat != dmm_pkg::LAT_IO) begin
						st_q <= DMM_WAIT;
						wait_q <= lat - 2'h1;
						rd_ee_q <= region == dmm_pkg::DMM_RG_EE;
						rd_idx_q <= ea[dmm_pkg::SRAM_IDX_W-1:0];
					end
				end
				DMM_WAIT: begin
					if (wait_q == 2'h1) begin
						st_q <= DMM_IDLE;
					end
					wait_q <= wait_q - 2'h1;
				end
				default: st_q <= DMM_IDLE;
			endcase
		end
	end

	assign o_busy = st_q == DMM_WAIT;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_ack <= 1'b0;
			o_err <= 1'b0;
			o_rdata <= 8'h00;
			o_bit_val <= 1'b0;
		end else begin
			o_ack <= 1'b0;
			o_err <= 1'b0;
			if (st_q == DMM_WAIT && wait_q == 2'h1) begin
				o_ack <= 1'b1;
				if (rd_ee_q) begin
					o_rdata <= ee_q[rd_idx_q[dmm_pkg::EE_IDX_W-1:0]];
				end else begin
					o_rdata <= sram_q[rd_idx_q];
				end
			end else if (take && (bad || lat == dmm_pkg::LAT_IO)) begin
				o_ack <= 1'b1;
				o_err <= bad;
				o_rdata <= bad ? 8'h00 : io_rd;
				o_bit_val <= !bad && io_rd[i_bit_sel];
			end
		end
	end

	// ---------------------------------------------------------------
	// Page addressing
	// ---------------------------------------------------------------
	dmm_page_addr u_page (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_flash_z(i_flash_z),
		.i_nvm_addr(i_nvm_addr),
		.o_flash_page_index(o_flash_page_index),
		.o_flash_word_in_page(o_flash_word_in_page),
		.o_flash_byte_sel(o_flash_byte_sel),
		.o_eeprom_page_index(o_eeprom_page_index),
		.o_eeprom_byte_in_page(o_eeprom_byte_in_page)
	);
endmodule

/* verilog/dmm_gpr_file.sv */
// General purpose I/O storage registers with no side effects.
`timescale 1ns/100ps
module dmm_gpr_file (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_we,
	input wire logic [dmm_pkg::GPR_IDX_W-1:0] i_idx,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata
);
	logic [7:0] reg_q [dmm_pkg::GPR_COUNT];

	for (genvar g = 0; g < dmm_pkg::GPR_COUNT; g++) begin : g_reg
		always_ff @(posedge i_clk) begin
			if (i_rst) begin
				reg_q[g] <= dmm_pkg::CFG_RST;
			end else if (i_we && i_idx == dmm_pkg::GPR_IDX_W'(g)) begin
				reg_q[g] <= i_wdata;
			end
		end
	end

	assign o_rdata = reg_q[i_idx];
endmodule

/* verilog/dmm_page_addr.sv */
// Splits flash and EEPROM pointers into page and in-page fields.
`timescale 1ns/100ps
module dmm_page_addr (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [dmm_pkg::FLASH_Z_W-1:0] i_flash_z,
	input wire logic [dmm_pkg::NVM_ADDR_W-1:0] i_nvm_addr,
	output logic [dmm_pkg::FLASH_PAGE_INDEX_W-1:0] o_flash_page_index,
	output logic [dmm_pkg::FLASH_WORD_IN_PAGE_W-1:0] o_flash_word_in_page,
	output logic o_flash_byte_sel,
	output logic [dmm_pkg::EE_PAGE_W-1:0] o_eeprom_page_index,
	output logic [dmm_pkg::EE_BYTE_W-1:0] o_eeprom_byte_in_page
);
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_flash_page_index <= '0;
			o_flash_word_in_page <= '0;
			o_flash_byte_sel <= 1'b0;
		end else begin
			// Bit 0 picks the byte of a word, since reads are bytewise.
			o_flash_byte_sel <= i_flash_z[0];
			o_flash_word_in_page <= i_flash_z[dmm_pkg::FLASH_WORD_IN_PAGE_W:1];
			o_flash_page_index <=
				i_flash_z[dmm_pkg::FLASH_Z_W-1:dmm_pkg::FLASH_WORD_IN_PAGE_W+1];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_eeprom_page_index <= '0;
			o_eeprom_byte_in_page <= '0;
		end else begin
			o_eeprom_byte_in_page <= i_nvm_addr[dmm_pkg::EE_BYTE_W-1:0];
			o_eeprom_page_index <=
				i_nvm_addr[dmm_pkg::NVM_ADDR_W-1:dmm_pkg::EE_BYTE_W];
		end
	end
endmodule
